// *** smd_map.svh ***
// constants of the management-memory decoder: offsets, fields, resets
// assumes a 32-bit host address space and byte addresses on the bus
// Contract
// - compat mode reserves A/B segments, uncached
// - compat, not in management mode: forward PCI
// - compat, in management mode: control bits pick target
// - never claim PCI master cycles to compat memory
// - illegal extended access sets error, goes PCI
// - top segment size 128K to 1M by field
// - top segment removed from ordinary memory top
// - 100A0000h-100FFFFFh maps onto DRAM 000A0000h up
// - top segment alias above 10000000h maps below top
// - A and B segments available when both enabled
// - C, D, E available unless used for shadowing
// - F available only for suspend and resume
// - top segment needs its enable and global enable
// - never claim bus-master access to extended memory
// - management mode active: defined ranges go DRAM
// - open override also sends defined ranges DRAM
// - modified-line write-backs always reach DRAM
// - extended memory is write-back cacheable
// - second level cache only below 32 Mbytes
`ifndef SMD_MAP_SVH
`define SMD_MAP_SVH
`define SMD_OFF_CTRL 8'h00
`define SMD_OFF_EXT 8'h04
`define SMD_OFF_TOM 8'h08
`define SMD_OFF_ATTR 8'h0C
`define SMD_OFF_STAT 8'h10
`define SMD_CTRL_GEN 3
`define SMD_CTRL_CLS 4
`define SMD_CTRL_OPN 5
`define SMD_EXT_HEN 0
`define SMD_EXT_TEN 1
`define SMD_EXT_TSZ 2
`define SMD_EXT_ERR 4
`define SMD_CTRL_RST 6'h02
`define SMD_EXT_RST 4'h0
`define SMD_TOM_RST 32'h0080_0000
`define SMD_ATTR_RST 4'h0
`define SMD_COMPAT_CODE 3'h2
`define SMD_AB_LO 32'h000A_0000
`define SMD_AB_HI 32'h000B_FFFF
`define SMD_HIGH_LO 32'h100A_0000
`define SMD_HIGH_HI 32'h100F_FFFF
`define SMD_LOW_HI 32'h000F_FFFF
`define SMD_EXT_BASE 32'h1000_0000
`define SMD_TOP_SMM_SEGMENT_MIN 32'h0002_0000
`define SMD_L2_LIMIT 32'h0200_0000
`define SMD_RESP_OK 2'h0
`define SMD_RESP_ERR 2'h2
`endif

// *** smd_pkg.sv ***
// types shared by the management-memory decoder
// assumes nothing beyond the constants header
package smd_pkg;
   typedef enum logic [2:0] {
      SMD_NORMAL = 3'b001,
      SMD_DRAM = 3'b010,
      SMD_PCI = 3'b100
   } smd_route_t;

   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic code;
      logic writeback;
   } smd_host_req_t;

   typedef struct packed {
      smd_route_t route;
      logic smm_hit;
      logic l1;
      logic l2;
      logic [31:0] dram_addr;
   } smd_dec_t;
endpackage

// *** smd_top.sv ***
// management-memory address decoder with an AXI4-Lite register file
// assumes host requests on aclk; smm_active_n arrives from a pin
`timescale 1ns/100ps
`default_nettype none
`include "smd_map.svh"
module smd_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic host_valid,
   input wire smd_pkg::smd_host_req_t host_req,
   input wire logic smm_active_n,
   input wire logic pci_valid,
   input wire logic [31:0] pci_addr,
   output logic dec_valid,
   output var smd_pkg::smd_dec_t dec_out,
   output logic pci_claim,
   output logic [31:0] usable_top
);

   function automatic logic in_rng(
      input logic [31:0] x,
      input logic [31:0] lo,
      input logic [31:0] hi
   );
      in_rng = (x >= lo) && (x <= hi);
   endfunction

   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0] strb
   );
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   logic [5:0] ctrl_ff;
   logic [3:0] ext_ff, attr_ff, wstrb_ff;
   logic [31:0] tom_ff, wdata_ff, rdata_ff, top_ff;
   logic err_ff, s1_ff, s2_ff, s3_ff, act_n_ff;
   logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
   logic dec_valid_ff, claim_ff;
   logic [7:0] awaddr_ff;
   logic [1:0] bresp_ff, rresp_ff;
   smd_pkg::smd_dec_t dec_ff;

   // pin synchroniser; level changes once two later stages agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
         act_n_ff <= 1'b1;
      end else begin
         s1_ff <= smm_active_n;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            act_n_ff <= s3_ff;
         end
      end
   end

   logic gen, cls, opn, act, compat_mode, ext_on, top_smm_segment_on;
   logic [31:0] top_smm_segment_sz, top_smm_segment_lo, a, a_off;
   logic in_compat, in_high, seg_ok, high_ok, top_smm_segment_hit, top_smm_segment_hole, l2_ok;

   assign gen = ctrl_ff[`SMD_CTRL_GEN];
   assign cls = ctrl_ff[`SMD_CTRL_CLS];
   assign opn = ctrl_ff[`SMD_CTRL_OPN];
   assign act = !act_n_ff;
   assign a = host_req.addr;
   assign a_off = a - `SMD_EXT_BASE;
   assign compat_mode = (ctrl_ff[2:0] == `SMD_COMPAT_CODE) && gen;
   assign ext_on = gen && ext_ff[`SMD_EXT_HEN];
   assign top_smm_segment_on = gen && ext_ff[`SMD_EXT_TEN];
   assign top_smm_segment_sz = `SMD_TOP_SMM_SEGMENT_MIN << ext_ff[`SMD_EXT_TSZ +: 2];
   assign top_smm_segment_lo = tom_ff - top_smm_segment_sz;
   assign l2_ok = tom_ff <= `SMD_L2_LIMIT;
   assign in_compat = in_rng(a, `SMD_AB_LO, `SMD_AB_HI);
   assign in_high = in_rng(a, `SMD_HIGH_LO, `SMD_HIGH_HI);

   // segment availability inside the high-memory area
   always_comb begin
      unique case (a[19:16])
         4'hA, 4'hB: seg_ok = 1'b1;
         4'hC: seg_ok = !attr_ff[0];
         4'hD: seg_ok = !attr_ff[1];
         4'hE: seg_ok = !attr_ff[2];
         4'hF: seg_ok = attr_ff[3];
         default: seg_ok = 1'b0;
      endcase
   end

   assign high_ok = ext_on && in_high && seg_ok;
   // the alias window sits exactly 10000000h above the removed block
   assign top_smm_segment_hit = top_smm_segment_on && (a >= `SMD_EXT_BASE)
      && in_rng(a_off, top_smm_segment_lo, tom_ff - 32'h0000_0001);
   assign top_smm_segment_hole = top_smm_segment_on
      && in_rng(a, top_smm_segment_lo, tom_ff - 32'h0000_0001);

   smd_pkg::smd_dec_t nxt_dec;
   logic nxt_err;

   always_comb begin
      nxt_dec.route = smd_pkg::SMD_NORMAL;
      nxt_dec.smm_hit = 1'b0;
      nxt_dec.l1 = 1'b1;
      nxt_dec.l2 = 1'b1;
      nxt_dec.dram_addr = a;
      nxt_err = 1'b0;
      if (compat_mode && in_compat) begin
         nxt_dec.smm_hit = 1'b1;
         nxt_dec.l1 = 1'b0;
         nxt_dec.l2 = 1'b0;
         // closed override keeps data on PCI, code still from DRAM
         if (host_req.writeback || opn
            || (act && !(cls && !host_req.code))) begin
            nxt_dec.route = smd_pkg::SMD_DRAM;
         end else begin
            nxt_dec.route = smd_pkg::SMD_PCI;
         end
      end else if (high_ok || top_smm_segment_hit) begin
         nxt_dec.smm_hit = 1'b1;
         if (high_ok) begin
            nxt_dec.dram_addr = {12'h000, a[19:0]};
         end else begin
            nxt_dec.dram_addr = a_off;
         end
         if (act || opn || host_req.writeback) begin
            nxt_dec.route = smd_pkg::SMD_DRAM;
            nxt_dec.l1 = 1'b1;
            nxt_dec.l2 = l2_ok;
         end else begin
            nxt_dec.route = smd_pkg::SMD_PCI;
            nxt_dec.l1 = 1'b0;
            nxt_dec.l2 = 1'b0;
            nxt_err = 1'b1;
         end
      end else if (top_smm_segment_hole) begin
         nxt_dec.route = smd_pkg::SMD_PCI;
         nxt_dec.l1 = 1'b0;
         nxt_dec.l2 = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dec_valid_ff <= 1'b0;
         dec_ff <= '{route: smd_pkg::SMD_NORMAL, default: '0};
      end else begin
         dec_valid_ff <= host_valid;
         if (host_valid) begin
            dec_ff <= nxt_dec;
         end
      end
   end

   // bus masters never reach management memory through this bridge
   logic nxt_claim;
   always_comb begin
      nxt_claim = pci_addr < top_ff;
      if (compat_mode && in_rng(pci_addr, `SMD_AB_LO, `SMD_AB_HI)) begin
         nxt_claim = 1'b0;
      end
      if (ext_on && in_rng(pci_addr, `SMD_AB_LO, `SMD_LOW_HI)) begin
         nxt_claim = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         claim_ff <= 1'b0;
      end else begin
         claim_ff <= pci_valid && nxt_claim;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         top_ff <= `SMD_TOM_RST;
      end else begin
         top_ff <= top_smm_segment_on ? top_smm_segment_lo : tom_ff;
      end
   end

   // AXI4-Lite write side; address and data may arrive in either order
   logic do_wr, wr_ok, wr_ctrl, wr_ext, wr_tom, wr_attr;
   assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_ctrl = do_wr && (awaddr_ff == `SMD_OFF_CTRL);
   assign wr_ext = do_wr && (awaddr_ff == `SMD_OFF_EXT);
   assign wr_tom = do_wr && (awaddr_ff == `SMD_OFF_TOM);
   assign wr_attr = do_wr && (awaddr_ff == `SMD_OFF_ATTR);
   assign wr_ok = wr_ctrl || wr_ext || wr_tom || wr_attr
      || (awaddr_ff == `SMD_OFF_STAT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         awaddr_ff <= 8'h00;
      end else if (s_axi_awvalid && !aw_hold_ff) begin
         aw_hold_ff <= 1'b1;
         awaddr_ff <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else if (s_axi_wvalid && !w_hold_ff) begin
         w_hold_ff <= 1'b1;
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
      end else if (do_wr) begin
         w_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= `SMD_RESP_OK;
      end else if (do_wr) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_ok ? `SMD_RESP_OK : `SMD_RESP_ERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   logic [31:0] wm_ctrl, wm_ext, wm_attr;
   assign wm_ctrl = merge({26'h0, ctrl_ff}, wdata_ff, wstrb_ff);
   assign wm_ext = merge({28'h0, ext_ff}, wdata_ff, wstrb_ff);
   assign wm_attr = merge({28'h0, attr_ff}, wdata_ff, wstrb_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= `SMD_CTRL_RST;
         ext_ff <= `SMD_EXT_RST;
         tom_ff <= `SMD_TOM_RST;
         attr_ff <= `SMD_ATTR_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= wm_ctrl[5:0];
         end
         if (wr_ext) begin
            ext_ff <= wm_ext[3:0];
         end
         if (wr_tom) begin
            tom_ff <= merge(tom_ff, wdata_ff, wstrb_ff);
         end
         if (wr_attr) begin
            attr_ff <= wm_attr[3:0];
         end
      end
   end

   // set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_ff <= 1'b0;
      end else if (host_valid && nxt_err) begin
         err_ff <= 1'b1;
      end else if (wr_ext && wstrb_ff[0] && wdata_ff[`SMD_EXT_ERR]) begin
         err_ff <= 1'b0;
      end
   end

   // read side; one beat, answer one cycle after the address
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         `SMD_OFF_CTRL: rd_mux = {26'h0, ctrl_ff};
         `SMD_OFF_EXT: rd_mux = {27'h0, err_ff, ext_ff};
         `SMD_OFF_TOM: rd_mux = tom_ff;
         `SMD_OFF_ATTR: rd_mux = {28'h0, attr_ff};
         `SMD_OFF_STAT: rd_mux = {26'h0, l2_ok, act,
            dec_ff.smm_hit, dec_ff.route};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `SMD_RESP_OK;
      end else if (s_axi_arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_mux;
         rresp_ff <= rd_ok ? `SMD_RESP_OK : `SMD_RESP_ERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_awready = !aw_hold_ff;
   assign s_axi_wready = !w_hold_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign dec_valid = dec_valid_ff;
   assign dec_out = dec_ff;
   assign pci_claim = claim_ff;
   assign usable_top = top_ff;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_compat_no_cache: assert property (
      host_valid && compat_mode && in_compat
      |=> dec_valid && !dec_out.l1 && !dec_out.l2)
      else $error("compat hit marked cacheable");
   a_compat_idle_pci: assert property (
      host_valid && compat_mode && in_compat && act_n_ff
      && !opn && !host_req.writeback
      |=> dec_out.route == smd_pkg::SMD_PCI)
      else $error("compat access outside mode not on PCI");
   a_compat_closed_data: assert property (
      host_valid && compat_mode && in_compat && !act_n_ff && cls
      && !host_req.code && !opn && !host_req.writeback
      |=> dec_out.route == smd_pkg::SMD_PCI)
      else $error("closed data access reached DRAM");
   a_pci_no_claim: assert property (
      pci_valid && compat_mode
      && pci_addr >= 32'h000A_0000 && pci_addr <= 32'h000B_FFFF
      |=> !pci_claim)
      else $error("PCI master claimed in compat memory");
   a_ext_err_set: assert property (
      host_valid && high_ok && act_n_ff && !opn
      && !host_req.writeback
      |=> err_ff && dec_out.route == smd_pkg::SMD_PCI)
      else $error("illegal extended access not flagged");
   a_err_sticky: assert property (
      err_ff && !wr_ext ##1 !wr_ext |-> err_ff)
      else $error("error bit dropped without clear");
   // a register write in the same cycle would move the reference
   a_top_smm_segment_top: assert property (
      top_smm_segment_on && !wr_ext && !wr_tom
      |=> usable_top == tom_ff - (32'h0002_0000 << ext_ff[3:2]))
      else $error("usable top not reduced by segment");
   a_high_map: assert property (
      host_valid && high_ok && !act_n_ff
      |=> dec_out.route == smd_pkg::SMD_DRAM
      && dec_out.dram_addr == ($past(a) & 32'h000F_FFFF))
      else $error("high area mapped wrongly");
   a_top_smm_segment_map: assert property (
      host_valid && top_smm_segment_hit && !high_ok && !act_n_ff
      |=> dec_out.dram_addr == $past(a) - 32'h1000_0000)
      else $error("top segment alias mapped wrongly");
   a_wb_dram: assert property (
      host_valid && host_req.writeback
      && ((compat_mode && in_compat) || high_ok)
      |=> dec_out.route == smd_pkg::SMD_DRAM)
      else $error("write-back into management memory blocked");
   a_l2_limit: assert property (
      host_valid && high_ok && !act_n_ff && tom_ff > 32'h0200_0000
      |=> dec_out.l1 && !dec_out.l2)
      else $error("L2 caching above limit");
endmodule // smd_top
`default_nettype wire

// *** smd_host_model.sv ***
// processor host bus and pci bus master model facing the decoder
// assumes its tasks are called right after a rising edge of aclk
`timescale 1ns/100ps
`default_nettype none
module smd_host_model (
   input wire logic aclk,
   output logic host_valid,
   output var smd_pkg::smd_host_req_t host_req,
   output logic smm_active_n,
   output logic pci_valid,
   output logic [31:0] pci_addr
);
   initial begin
      host_valid = 1'b0;
      host_req = '0;
      smm_active_n = 1'b1;
      pci_valid = 1'b0;
      pci_addr = 32'h0000_0000;
   end

   // idle lines show the inverse, writeback held low, so a stale address never decodes
   task automatic cyc(input logic [31:0] a, input logic wb);
      host_valid <= 1'b1;
      host_req <= '{addr: a, write: wb, code: 1'b0, writeback: wb};
      @(posedge aclk);
      host_valid <= 1'b0;
      host_req <= '{addr: ~a, write: ~wb, code: 1'b1, writeback: 1'b0};
   endtask

   // pin passes a synchroniser inside, so give it time to land
   task automatic system_management_mode(input logic act_n);
      smm_active_n <= act_n;
      repeat (6) @(posedge aclk);
   endtask

   task automatic pci(input logic [31:0] a);
      pci_valid <= 1'b1;
      pci_addr <= a;
      @(posedge aclk);
      pci_valid <= 1'b0;
      pci_addr <= ~a;
   endtask
endmodule // smd_host_model
`default_nettype wire

// *** smd_ram_decoder_test.sv ***
// self-checking bench for the management-memory decoder
// assumes the host model drives the host and pci master inputs
`timescale 1ns/100ps
`default_nettype none
`include "smd_map.svh"
module smd_ram_decoder_test;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, usable_top;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, dec_valid, pci_claim;
   smd_pkg::smd_dec_t dec_out;
   wire logic host_valid, smm_active_n, pci_valid;
   wire smd_pkg::smd_host_req_t host_req;
   wire logic [31:0] pci_addr;
   int errors, checks_done, seed;
   logic [31:0] top_of_memory, ra, ts;
   localparam smd_pkg::smd_route_t rt_nrm = smd_pkg::SMD_NORMAL;
   localparam smd_pkg::smd_route_t rt_drm = smd_pkg::SMD_DRAM;
   localparam smd_pkg::smd_route_t rt_pci = smd_pkg::SMD_PCI;

   smd_top uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .host_valid(host_valid),
      .host_req(host_req), .smm_active_n(smm_active_n),
      .pci_valid(pci_valid), .pci_addr(pci_addr), .dec_valid(dec_valid),
      .dec_out(dec_out), .pci_claim(pci_claim), .usable_top(usable_top));

   smd_host_model hm (.aclk(aclk), .host_valid(host_valid),
      .host_req(host_req), .smm_active_n(smm_active_n),
      .pci_valid(pci_valid), .pci_addr(pci_addr));

   always #2 aclk = ~aclk;

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] tsz(input logic [1:0] s);
      return `SMD_TOP_SMM_SEGMENT_MIN << s;
   endfunction

   // a plain forward below the alias base is the hidden top block
   function automatic logic exp_hit(input logic [31:0] a,
                                    input smd_pkg::smd_route_t r);
      return (r != rt_nrm) && !(r == rt_pci && a < `SMD_EXT_BASE
         && !(a >= `SMD_AB_LO && a <= `SMD_AB_HI));
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'b0;
      cmp({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er,
                     input logic [31:0] ed);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'b0;
      cmp({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
      cmp(s_axi_rdata, ed);
      @(posedge aclk);
   endtask

   // dram address only means something when the cycle is not forwarded
   task automatic hc(input logic [31:0] a, input logic wb,
                     input smd_pkg::smd_route_t r, input logic [1:0] l,
                     input logic [31:0] da);
      hm.cyc(a, wb);
      @(posedge aclk);
      cmp({dec_valid, dec_out.route, dec_out.l1, dec_out.l2}, {1'b1, r, l});
      cmp(dec_out.smm_hit, exp_hit(a, r));
      if (r != smd_pkg::SMD_PCI)
         cmp(dec_out.dram_addr, da);
   endtask

   task automatic pc(input logic [31:0] a, input logic c);
      hm.pci(a);
      @(posedge aclk);
      cmp(pci_claim, c);
   endtask

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      seed = 5186;
      top_of_memory = `SMD_TOM_RST;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SMD_OFF_CTRL, `SMD_RESP_OK, 32'h0000_0002);
      rd(`SMD_OFF_EXT, `SMD_RESP_OK, 32'h0000_0000);
      rd(`SMD_OFF_TOM, `SMD_RESP_OK, top_of_memory);
      rd(`SMD_OFF_ATTR, `SMD_RESP_OK, 32'h0000_0000);
      rd(8'h14, `SMD_RESP_ERR, 32'h0000_0000);
      wr(8'h14, 32'hFFFF_FFFF, `SMD_RESP_ERR);
      cmp(usable_top, top_of_memory);
      for (int i = 0; i < 16; i++) begin
         ra = 32'($random(seed)) & 32'h0007_FFFC;
         hc(ra, 1'b0, smd_pkg::SMD_NORMAL, 2'b11, ra);
         pc(ra, 1'b1);
      end
      wr(`SMD_OFF_CTRL, 32'h0000_000A, `SMD_RESP_OK);
      hc(32'h000A_1000, 1'b0, rt_pci, 2'b00, 0);
      hc(32'h000B_FFFC, 1'b1, rt_drm, 2'b00, 32'h000B_FFFC);
      hc(32'h000C_0000, 1'b0, rt_nrm, 2'b11, 32'h000C_0000);
      pc(32'h000A_0000, 1'b0);
      pc(32'h000B_FFFC, 1'b0);
      hm.system_management_mode(1'b0);
      hc(32'h000A_1000, 1'b0, rt_drm, 2'b00, 32'h000A_1000);
      wr(`SMD_OFF_CTRL, 32'h0000_001A, `SMD_RESP_OK);
      hc(32'h000A_1000, 1'b0, rt_pci, 2'b00, 0);
      hm.system_management_mode(1'b1);
      wr(`SMD_OFF_CTRL, 32'h0000_0008, `SMD_RESP_OK);
      wr(`SMD_OFF_EXT, 32'h0000_0001, `SMD_RESP_OK);
      hc(32'h100B_0000, 1'b1, rt_drm, 2'b11, 32'h000B_0000);
      hc(32'h100A_0000, 1'b0, rt_pci, 2'b00, 0);
      rd(`SMD_OFF_EXT, `SMD_RESP_OK, 32'h0000_0011);
      hc(32'h0001_0000, 1'b0, rt_nrm, 2'b11, 32'h0001_0000);
      rd(`SMD_OFF_EXT, `SMD_RESP_OK, 32'h0000_0011);
      wr(`SMD_OFF_EXT, 32'h0000_0011, `SMD_RESP_OK);
      rd(`SMD_OFF_EXT, `SMD_RESP_OK, 32'h0000_0001);
      pc(32'h000C_0000, 1'b0);
      wr(`SMD_OFF_CTRL, 32'h0000_0028, `SMD_RESP_OK);
      hc(32'h100A_0000, 1'b0, rt_drm, 2'b11, 32'h000A_0000);
      // status: below limit, mode inactive, hit, routed to DRAM
      rd(`SMD_OFF_STAT, `SMD_RESP_OK, 32'h0000_002A);
      wr(`SMD_OFF_CTRL, 32'h0000_0008, `SMD_RESP_OK);
      hm.system_management_mode(1'b0);
      hc(32'h100B_FFFC, 1'b0, rt_drm, 2'b11, 32'h000B_FFFC);
      wr(`SMD_OFF_TOM, 32'h0400_0000, `SMD_RESP_OK);
      hc(32'h100B_FFFC, 1'b0, rt_drm, 2'b10, 32'h000B_FFFC);
      wr(`SMD_OFF_TOM, top_of_memory, `SMD_RESP_OK);
      for (int k = 0; k < 3; k++) begin
         ra = 32'h100C_0000 + 32'(k << 16);
         wr(`SMD_OFF_ATTR, 32'(1 << k), `SMD_RESP_OK);
         hc(ra, 1'b0, rt_nrm, 2'b11, ra);
         wr(`SMD_OFF_ATTR, 32'h0000_0000, `SMD_RESP_OK);
         hc(ra, 1'b0, rt_drm, 2'b11, ra - `SMD_EXT_BASE);
      end
      hc(32'h100F_0000, 1'b0, rt_nrm, 2'b11, 32'h100F_0000);
      wr(`SMD_OFF_ATTR, 32'h0000_0008, `SMD_RESP_OK);
      hc(32'h100F_0000, 1'b0, rt_drm, 2'b11, 32'h000F_0000);
      wr(`SMD_OFF_EXT, 32'h0000_0000, `SMD_RESP_OK);
      hc(32'h100A_0000, 1'b0, rt_nrm, 2'b11, 32'h100A_0000);
      for (int s = 0; s < 4; s++) begin
         ts = tsz(2'(s));
         wr(`SMD_OFF_EXT, {28'h0, 2'(s), 2'b10}, `SMD_RESP_OK);
         cmp(usable_top, top_of_memory - ts);
         hc(`SMD_EXT_BASE + top_of_memory - ts, 1'b0, rt_drm, 2'b11, top_of_memory - ts);
         hc(top_of_memory - ts, 1'b0, rt_pci, 2'b00, 0);
         // status: below limit, mode active, no hit, forwarded
         rd(`SMD_OFF_STAT, `SMD_RESP_OK, 32'h0000_0034);
         pc(top_of_memory - ts, 1'b0);
      end
      wr(`SMD_OFF_CTRL, 32'h0000_0000, `SMD_RESP_OK);
      cmp(usable_top, top_of_memory);
      end_of_test;
   end

   // the sequence needs a few hundred cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      end_of_test;
   end
endmodule // smd_ram_decoder_test
`default_nettype wire
